// file: hyst_compare.sv
`timescale 1ns/1ps
module hyst_compare
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        enable,
   input  wire logic [15:0] value,
   input  wire logic [15:0] level,
   output wire logic        above
);
   // Set on rising past level, cleared on falling below, held when equal
   logic above_r;
   logic above_nxt;

   assign above_nxt = !enable      ? 1'b0 :
                      value > level ? 1'b1 :
                      value < level ? 1'b0 : above_r;
   assign above = above_r;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         above_r <= 1'b0;
      else
         above_r <= above_nxt;
   end

endmodule

// file: pct_scale.sv
`timescale 1ns/1ps
module pct_scale
   import supervisor_pkg::*;
(
   input  wire logic [15:0] base,
   input  wire logic [9:0]  per_mille,
   output wire logic [15:0] scaled
);
   // Scales a value by a fraction in units of 0.1 %
   wire logic [25:0] prod;
   wire logic [25:0] quot;

   assign prod   = base * per_mille;
   assign quot   = prod / 26'({16'h0000, PM_FULL});
   assign scaled = quot[15:0];

endmodule

// file: pump_drive_supervisor.sv
// Function
// - Time motor run-up against a settable limit; flag an error when exceeded.
// - Cap drive power at a settable share of full power; full share by default.
// - Switchpoint output and status rise above the active level, fall below it.
// - Switchpoint mode 0 uses only switchpoint level one.
// - Switchpoint mode 1 uses level one while pumping, level two otherwise.
// - Speed-setting mode regulates to its set share and ignores standby.
// - In speed-setting mode the switchpoint scales with the reduced set speed.
// - In speed-setting mode set-speed-attained follows crossings of the set speed.
// - Standby lowers speed to its level, default 66.7 %, and drives attained.
// - Backing pump mode: 0 continuous, 1 intermittent, 2 delayed switch-on.
// - Continuous mode drives the backing pump whenever the sequencer is in the run state.
// - Intermittent mode switches the backing pump on drive power thresholds.
// - Delayed mode holds the backing pump off until speed exceeds 6 Hz.
// - Pumping on with motor enabled clears errors, self-tests, then starts only if the self-test passes.
// - In the run state, the motor follows the motor enable setting unless a run-up error is set.
// - Pumping written 0 stops the turbopump and starts accessory actions.
// - Venting outputs follow pumping off after a fixed 6 s delay.
`timescale 1ns/1ps
module pump_drive_supervisor
   import supervisor_pkg::*;
#(
   parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic [15:0] rotor_speed_hz,
   input  wire logic [15:0] drive_power,
   input  wire logic        selftest_pass,
   output logic             motor_run,
   output logic [15:0]      speed_target_hz,
   output logic [9:0]       power_limit_pm,
   output logic             switchpoint_out,
   output logic             backing_pump_out,
   output logic             vent_out
);

   logic [CTRL_W-1:0] ctrl_r;
   logic [15:0]       run_up_time_limit_r;
   logic [9:0]        pwr_lim_r;
   logic [9:0]        sp1_r;
   logic [9:0]        sp2_r;
   logic [9:0]        set_spd_r;
   logic [9:0]        standby_r;
   logic [15:0]       bp_on_r;
   logic [15:0]       bp_off_r;
   logic [15:0]       nominal_r;
   logic [31:0]       readdata_r;
   logic              waitrequest_r;
   seq_state_t        state_r;
   seq_state_t        state_nxt;
   logic [4:0]        test_cnt_r;
   logic              pumping_d_r;
   logic              runup_err_r;
   logic              test_err_r;
   logic              runup_done_r;
   logic [31:0]       presc_r;
   logic [15:0]       runup_secs_r;
   logic              vent_armed_r;
   logic [15:0]       vent_secs_r;
   logic              motor_r;
   logic [15:0]       target_r;
   logic              sp_out_r;
   logic              bp_r;
   logic              bp_interm_r;
   logic              bp_delay_ok_r;
   logic              vent_r;

   // Bus decode
   wire logic        access;
   wire logic        wr_go;
   wire logic [31:0] wmask;
   wire logic        hit_ctrl;
   wire logic        hit_runup;
   wire logic        hit_pwr;
   wire logic        hit_sp1;
   wire logic        hit_sp2;
   wire logic        hit_set;
   wire logic        hit_stby;
   wire logic        hit_bp_on;
   wire logic        hit_bp_off;
   wire logic        hit_nom;
   wire logic [31:0] rd_mux;
   wire logic [31:0] status_word;
   wire logic        set_speed_attained;
   wire logic [31:0] wr_m;

   assign access     = read | write;
   assign wr_go      = write & ~waitrequest_r;
   assign hit_ctrl   = wr_go & (address == OFS_CTRL);
   assign hit_runup  = wr_go & (address == OFS_RUNUP);
   assign hit_pwr    = wr_go & (address == OFS_PWR_LIM);
   assign hit_sp1    = wr_go & (address == OFS_SP1);
   assign hit_sp2    = wr_go & (address == OFS_SP2);
   assign hit_set    = wr_go & (address == OFS_SET_SPD);
   assign hit_stby   = wr_go & (address == OFS_STANDBY);
   assign hit_bp_on  = wr_go & (address == OFS_BP_ON);
   assign hit_bp_off = wr_go & (address == OFS_BP_OFF);
   assign hit_nom    = wr_go & (address == OFS_NOMINAL);

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++)
      begin : g_mask
         assign wmask[8*gb +: 8] = {8{byteenable[gb]}};
      end
   endgenerate

   function automatic logic [9:0] clamp_pm(input logic [31:0] v);
      clamp_pm = (v[15:0] > {6'h00, PM_FULL}) ? PM_FULL : v[9:0];
   endfunction

   assign status_word = {22'h00_0000, state_r, runup_done_r, vent_r, bp_r, motor_r,
                         test_err_r, runup_err_r, set_speed_attained, sp_out_r};

   assign rd_mux = (address == OFS_CTRL)    ? {24'h0000_00, ctrl_r} :
                   (address == OFS_RUNUP)   ? {16'h0000, run_up_time_limit_r} :
                   (address == OFS_PWR_LIM) ? {22'h00_0000, pwr_lim_r} :
                   (address == OFS_SP1)     ? {22'h00_0000, sp1_r} :
                   (address == OFS_SP2)     ? {22'h00_0000, sp2_r} :
                   (address == OFS_SET_SPD) ? {22'h00_0000, set_spd_r} :
                   (address == OFS_STANDBY) ? {22'h00_0000, standby_r} :
                   (address == OFS_BP_ON)   ? {16'h0000, bp_on_r} :
                   (address == OFS_BP_OFF)  ? {16'h0000, bp_off_r} :
                   (address == OFS_NOMINAL) ? {16'h0000, nominal_r} :
                   (address == OFS_STATUS)  ? status_word :
                   (address == OFS_SPEED)   ? {16'h0000, rotor_speed_hz} : 32'h0000_0000;

   assign wr_m = (rd_mux & ~wmask) | (writedata & wmask);

   // Control bits
   wire logic       pumping;
   wire logic       motor_en;
   wire logic       spd_mode;
   wire logic       stby_mode;
   wire logic       sp_mode;
   wire logic [1:0] bp_mode;
   wire logic       vent_en;

   assign pumping   = ctrl_r[CTRL_PUMPING];
   assign motor_en  = ctrl_r[CTRL_MOTOR];
   assign spd_mode  = ctrl_r[CTRL_SPD_SET];
   assign stby_mode = ctrl_r[CTRL_STANDBY] & ~spd_mode;
   assign sp_mode   = ctrl_r[CTRL_SP_MODE];
   assign bp_mode   = ctrl_r[CTRL_BP_LO +: 2];
   assign vent_en   = ctrl_r[CTRL_VENT_EN];

   // Speed targets and switchpoint levels
   wire logic [9:0]  target_pm;
   wire logic [15:0] target_hz;
   wire logic [15:0] sp_base;
   wire logic [9:0]  sp_pm;
   wire logic [15:0] sp_level;
   wire logic        sp_above;

   assign target_pm = spd_mode  ? set_spd_r :
                      stby_mode ? standby_r :
                      PM_FULL;
   assign sp_base   = spd_mode ? target_hz : nominal_r;
   assign sp_pm     = (sp_mode && !pumping) ? sp2_r : sp1_r;

   pct_scale u_target
   (
      .base      (nominal_r),
      .per_mille (target_pm),
      .scaled    (target_hz)
   );

   pct_scale u_sp_level
   (
      .base      (sp_base),
      .per_mille (sp_pm),
      .scaled    (sp_level)
   );

   hyst_compare u_switchpoint
   (
      .clk    (clk),
      .nrst   (nrst),
      .enable (1'b1),
      .value  (rotor_speed_hz),
      .level  (sp_level),
      .above  (sp_above)
   );

   hyst_compare u_attained
   (
      .clk    (clk),
      .nrst   (nrst),
      .enable (spd_mode | stby_mode),
      .value  (rotor_speed_hz),
      .level  (target_hz),
      .above  (set_speed_attained)
   );

   // Sequencing
   wire logic pump_rise;
   wire logic test_done;
   wire logic motor_nxt;
   wire logic sec_tick;
   wire logic runup_over;
   wire logic presc_clr;

   assign pump_rise = pumping & ~pumping_d_r;
   assign test_done = (test_cnt_r == SELFTEST_CYCLES);
   assign sec_tick  = (presc_r == 32'(SEC_CYCLES_P - 1));
   assign motor_nxt = (state_r == S_RUN) & motor_en & ~runup_err_r;
   assign runup_over = runup_secs_r > run_up_time_limit_r;
   assign presc_clr  = sec_tick | (pumping_d_r & ~pumping);

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
            if (pump_rise && motor_en)
               state_nxt = S_TEST;
         S_TEST:
            if (!pumping)
               state_nxt = S_IDLE;
            else if (test_done)
               state_nxt = selftest_pass ? S_RUN : S_IDLE;
         S_RUN:
            if (!pumping)
               state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   // Backing pump
   wire logic bp_interm_nxt;
   wire logic bp_delay_nxt;
   wire logic bp_nxt;

   assign bp_interm_nxt = !motor_r ? 1'b0 :
                          (drive_power >= bp_on_r)  ? 1'b1 :
                          (drive_power <= bp_off_r) ? 1'b0 : bp_interm_r;
   assign bp_delay_nxt  = (state_r == S_RUN) &
                          (bp_delay_ok_r | (rotor_speed_hz > DELAY_SPEED_HZ));
   assign bp_nxt = (state_r != S_RUN)     ? 1'b0 :
                   (bp_mode == BP_CONT)    ? 1'b1 :
                   (bp_mode == BP_INTERM)  ? bp_interm_r :
                   (bp_mode == BP_DELAYED) ? bp_delay_ok_r :
                   1'b0;

   // Bus slave
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         waitrequest_r <= 1'b1;
         readdata_r    <= 32'h0000_0000;
      end
      else
      begin
         waitrequest_r <= ~(access & waitrequest_r);
         if (read && waitrequest_r)
            readdata_r <= rd_mux;
      end
   end

   // Register file
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl_r              <= CTRL_RST;
         run_up_time_limit_r <= RUNUP_RST;
         pwr_lim_r           <= PM_FULL;
         sp1_r               <= SP1_RST;
         sp2_r               <= SP2_RST;
         set_spd_r           <= SET_SPD_RST;
         standby_r           <= STANDBY_RST;
         bp_on_r             <= BP_ON_RST;
         bp_off_r            <= BP_OFF_RST;
         nominal_r           <= NOMINAL_RST;
      end
      else
      begin
         if (hit_ctrl)
            ctrl_r <= wr_m[CTRL_W-1:0];
         if (hit_runup)
            run_up_time_limit_r <= wr_m[15:0];
         if (hit_pwr)
            pwr_lim_r <= clamp_pm(wr_m);
         if (hit_sp1)
            sp1_r <= clamp_pm(wr_m);
         if (hit_sp2)
            sp2_r <= clamp_pm(wr_m);
         if (hit_set)
            set_spd_r <= clamp_pm(wr_m);
         if (hit_stby)
            standby_r <= clamp_pm(wr_m);
         if (hit_bp_on)
            bp_on_r <= wr_m[15:0];
         if (hit_bp_off)
            bp_off_r <= wr_m[15:0];
         if (hit_nom)
            nominal_r <= wr_m[15:0];
      end
   end

   // Sequencer, self-test and self-test error
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_r     <= S_IDLE;
         pumping_d_r <= 1'b0;
         test_cnt_r  <= 5'h00;
         test_err_r  <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         pumping_d_r <= pumping;
         test_cnt_r  <= (state_r == S_TEST) ? test_cnt_r + 5'h01 : 5'h00;
         if (state_r == S_IDLE && state_nxt == S_TEST)
            test_err_r <= 1'b0;
         else if (state_r == S_TEST && test_done && pumping && !selftest_pass)
            test_err_r <= 1'b1;
      end
   end

   // Run-up monitor
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         presc_r      <= 32'h0000_0000;
         runup_secs_r <= 16'h0000;
         runup_done_r <= 1'b0;
         runup_err_r  <= 1'b0;
      end
      else
      begin
         presc_r <= presc_clr ? 32'h0000_0000 : presc_r + 32'h0000_0001;
         if (state_r == S_TEST)
         begin
            runup_secs_r <= 16'h0000;
            runup_done_r <= 1'b0;
            runup_err_r  <= 1'b0;
         end
         else if (motor_r && !runup_done_r)
         begin
            if (rotor_speed_hz >= target_r)
               runup_done_r <= 1'b1;
            else if (sec_tick && runup_secs_r != 16'hFFFF)
               runup_secs_r <= runup_secs_r + 16'h0001;
            if (runup_over)
               runup_err_r <= 1'b1;
         end
      end
   end

   // Venting delay after pumping off
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         vent_armed_r <= 1'b0;
         vent_secs_r  <= 16'h0000;
         vent_r       <= 1'b0;
      end
      else
      begin
         if (pumping)
         begin
            vent_armed_r <= 1'b0;
            vent_secs_r  <= 16'h0000;
         end
         else
         begin
            if (pumping_d_r)
               vent_armed_r <= 1'b1;
            if (vent_armed_r && sec_tick && vent_secs_r != VENT_DELAY_S)
               vent_secs_r <= vent_secs_r + 16'h0001;
         end
         vent_r <= vent_en & vent_armed_r & ~pumping & (vent_secs_r == VENT_DELAY_S);
      end
   end

   // Output drivers
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         motor_r       <= 1'b0;
         target_r      <= 16'h0000;
         sp_out_r      <= 1'b0;
         bp_r          <= 1'b0;
         bp_interm_r   <= 1'b0;
         bp_delay_ok_r <= 1'b0;
      end
      else
      begin
         motor_r       <= motor_nxt;
         target_r      <= target_hz;
         sp_out_r      <= sp_above;
         bp_interm_r   <= bp_interm_nxt;
         bp_delay_ok_r <= bp_delay_nxt;
         bp_r          <= bp_nxt;
      end
   end

   assign readdata         = readdata_r;
   assign waitrequest      = waitrequest_r;
   assign motor_run        = motor_r;
   assign speed_target_hz  = target_r;
   assign power_limit_pm   = pwr_lim_r;
   assign switchpoint_out  = sp_out_r;
   assign backing_pump_out = bp_r;
   assign vent_out         = vent_r;

endmodule

// file: pump_drive_supervisor_checker.sv
`timescale 1ns/1ps
module pump_drive_supervisor_checker
   import supervisor_pkg::*;
#(
   parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic [15:0] rotor_speed_hz,
   input wire logic        motor_run,
   input wire logic [15:0] speed_target_hz,
   input wire logic [9:0]  power_limit_pm,
   input wire logic        switchpoint_out,
   input wire logic        backing_pump_out,
   input wire logic        vent_out
);
   logic [31:0] off_cnt_r;
   logic [31:0] off_cnt_nxt;

   // Cycles since the motor last ran, saturating
   assign off_cnt_nxt = motor_run ? 32'h0000_0000 :
                        (off_cnt_r == 32'hFFFF_FFFF) ? off_cnt_r : off_cnt_r + 32'h0000_0001;

   always_ff @(posedge clk)
   begin
      off_cnt_r <= nrst ? off_cnt_nxt : 32'h0000_0000;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus request not answered after one wait");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   idle_wait_a: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest dropped without a request");
   reset_out_a: assert property ($rose(nrst) |-> waitrequest && !motor_run && !vent_out
      && !backing_pump_out && power_limit_pm == PM_FULL ##1 speed_target_hz == NOMINAL_RST)
      else $error("outputs wrong after reset");
   power_cap_a: assert property (power_limit_pm <= PM_FULL)
      else $error("power limit above full");
   speed_read_a: assert property (read && !waitrequest && address == OFS_SPEED
      |-> readdata == {16'h0000, $past(rotor_speed_hz)}) else $error("speed read wrong");
   unmapped_read_a: assert property (read && !waitrequest && address > OFS_SPEED
      |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
   vent_delay_a: assert property ($rose(vent_out) |-> off_cnt_r >= 6 * SEC_CYCLES_P - 4)
      else $error("vent output too early");
   vent_motor_a: assert property (vent_out |-> !motor_run && !backing_pump_out)
      else $error("vent while pump driven");

   cover property ($rose(motor_run));
   cover property ($rose(vent_out));
   cover property ($rose(switchpoint_out));
   cover property ($rose(backing_pump_out));
endmodule

bind pump_drive_supervisor pump_drive_supervisor_checker #(.SEC_CYCLES_P(SEC_CYCLES_P))
   i_pump_drive_supervisor_checker (.clk(clk), .nrst(nrst), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .rotor_speed_hz(rotor_speed_hz), .motor_run(motor_run), .speed_target_hz(speed_target_hz),
   .power_limit_pm(power_limit_pm), .switchpoint_out(switchpoint_out),
   .backing_pump_out(backing_pump_out), .vent_out(vent_out));

// file: rotor_model.sv
`timescale 1ns/1ps
module rotor_model
(
   input  wire logic        clk,
   input  wire logic        motor_run,
   input  wire logic [15:0] speed_target_hz,
   input  wire logic        force_en,
   input  wire logic [15:0] force_spd,
   input  wire logic [15:0] power_set,
   output logic      [15:0] rotor_speed_hz,
   output logic      [15:0] drive_power
);
   logic [15:0] spd_r;
   logic [15:0] spd_nxt;

   // Rotor ramps up to target while driven and coasts down otherwise
   assign spd_nxt = force_en ? force_spd :
                    (motor_run && spd_r < speed_target_hz) ? spd_r + 16'h0004 :
                    (!motor_run && spd_r >= 16'h0004) ? spd_r - 16'h0004 : spd_r;
   assign rotor_speed_hz = spd_r;
   assign drive_power    = motor_run ? power_set : 16'h0000;

   always_ff @(posedge clk)
   begin
      spd_r <= spd_nxt;
   end
endmodule

// file: supervisor_pkg.sv
package supervisor_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_RUNUP     = 8'h04;
   localparam logic [7:0] OFS_PWR_LIM   = 8'h08;
   localparam logic [7:0] OFS_SP1       = 8'h0C;
   localparam logic [7:0] OFS_SP2       = 8'h10;
   localparam logic [7:0] OFS_SET_SPD   = 8'h14;
   localparam logic [7:0] OFS_STANDBY   = 8'h18;
   localparam logic [7:0] OFS_BP_ON     = 8'h1C;
   localparam logic [7:0] OFS_BP_OFF    = 8'h20;
   localparam logic [7:0] OFS_NOMINAL   = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   localparam logic [7:0] OFS_SPEED     = 8'h2C;

   // Control register fields
   localparam int CTRL_PUMPING  = 0;
   localparam int CTRL_MOTOR    = 1;
   localparam int CTRL_STANDBY  = 2;
   localparam int CTRL_SPD_SET  = 3;
   localparam int CTRL_SP_MODE  = 4;
   localparam int CTRL_BP_LO    = 5;
   localparam int CTRL_VENT_EN  = 7;
   localparam int CTRL_W        = 8;

   // Status register fields
   localparam int ST_SWITCHPT   = 0;
   localparam int ST_ATTAINED   = 1;
   localparam int ST_RUNUP_ERR  = 2;
   localparam int ST_TEST_ERR   = 3;
   localparam int ST_MOTOR      = 4;
   localparam int ST_BACKING    = 5;
   localparam int ST_VENT       = 6;
   localparam int ST_RUNUP_DONE = 7;
   localparam int ST_STATE_LO   = 8;

   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST    = 8'h02;
   localparam logic [15:0]       RUNUP_RST   = 16'h01E0;
   localparam logic [9:0]        PM_FULL     = 10'h3E8;
   localparam logic [9:0]        SP1_RST     = 10'h320;
   localparam logic [9:0]        SP2_RST     = 10'h320;
   localparam logic [9:0]        SET_SPD_RST = 10'h3E8;
   localparam logic [9:0]        STANDBY_RST = 10'h29B;
   localparam logic [15:0]       BP_ON_RST   = 16'h0000;
   localparam logic [15:0]       BP_OFF_RST  = 16'h0000;
   localparam logic [15:0]       NOMINAL_RST = 16'h05DC;

   // Backing pump modes
   localparam logic [1:0] BP_CONT    = 2'h0;
   localparam logic [1:0] BP_INTERM  = 2'h1;
   localparam logic [1:0] BP_DELAYED = 2'h2;

   // Timing
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          SEC_S           = 1;
   localparam int          SEC_CYCLES      = SEC_S * CLK_HZ;
   localparam logic [15:0] VENT_DELAY_S    = 16'h0006;
   localparam logic [15:0] DELAY_SPEED_HZ  = 16'h0006;
   localparam logic [4:0]  SELFTEST_CYCLES = 5'h10;

   typedef enum logic [1:0]
   {
      S_IDLE = 2'b00,
      S_TEST = 2'b01,
      S_RUN  = 2'b10
   } seq_state_t;

endpackage

// file: test_pump_drive_supervisor.sv
`timescale 1ns/1ps
module test_pump_drive_supervisor
   import supervisor_pkg::*;
;
   localparam int SEC = 20;
   logic        clk, nrst, read, write, selftest_pass, force_en, motor_run, waitrequest;
   logic        switchpoint_out, backing_pump_out, vent_out;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, rdata;
   logic [15:0] rotor_speed_hz, drive_power, speed_target_hz, force_spd, power_set;
   logic [9:0]  power_limit_pm;
   int          n_mismatch = 0;
   int          n_tests = 0;
   logic [7:0]  ra [9] = '{OFS_CTRL, OFS_RUNUP, OFS_PWR_LIM, OFS_SP1, OFS_SP2, OFS_SET_SPD,
                           OFS_STANDBY, OFS_NOMINAL, 8'h30};
   logic [31:0] rv [9] = '{32'h0000_0002, 32'h0000_01E0, 32'h0000_03E8, 32'h0000_0320,
                           32'h0000_0320, 32'h0000_03E8, 32'h0000_029B, 32'h0000_05DC, 32'h0};

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   pump_drive_supervisor #(.SEC_CYCLES_P(SEC)) i_pump_drive_supervisor (.clk(clk),
      .nrst(nrst), .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
      .rotor_speed_hz(rotor_speed_hz), .drive_power(drive_power),
      .selftest_pass(selftest_pass), .motor_run(motor_run), .speed_target_hz(speed_target_hz),
      .power_limit_pm(power_limit_pm), .switchpoint_out(switchpoint_out),
      .backing_pump_out(backing_pump_out), .vent_out(vent_out));

   rotor_model i_rotor_model (.clk(clk), .motor_run(motor_run),
      .speed_target_hz(speed_target_hz), .force_en(force_en), .force_spd(force_spd),
      .power_set(power_set), .rotor_speed_hz(rotor_speed_hz), .drive_power(drive_power));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= w;
      read      <= !w;
      @(posedge clk);
      while (waitrequest) @(posedge clk);
      rdata = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, rdata, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic spd(input logic [15:0] s);
      force_spd <= s;
      cyc(4);
   endtask

   task automatic stat(input string nm, input int b, input logic e);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(nm, rdata[b], e);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      cyc(3000);
      n_mismatch++;
      wrap_up;
   end

   initial
   begin
      nrst = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
      selftest_pass = 1'b0; force_en = 1'b1; force_spd = 16'h0000; power_set = 16'h0000;
      cyc(8);
      nrst <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 9; i++) rd("reset value", ra[i], rv[i]);
      chk("power port", power_limit_pm, 32'h0000_03E8);
      wr(OFS_PWR_LIM, 32'h0000_01F4);
      chk("power port", power_limit_pm, 32'h0000_01F4);
      wr(OFS_PWR_LIM, 32'h0000_07D0);
      chk("power port", power_limit_pm, 32'h0000_03E8);
      wr(OFS_RUNUP, 32'h0000_FFFF);
      wr(OFS_NOMINAL, 32'h0000_05DC);
      $display("test registers done");
      wr(OFS_CTRL, 32'h0000_0003);
      cyc(20);
      rd("status", OFS_STATUS, 32'h0000_0008);
      wr(OFS_CTRL, 32'h0000_0002);
      selftest_pass <= 1'b1;
      wr(OFS_CTRL, 32'h0000_0003);
      cyc(20);
      rd("status", OFS_STATUS, 32'h0000_0230);
      chk("motor", motor_run, 1);
      chk("backing", backing_pump_out, 1);
      wr(OFS_CTRL, 32'h0000_0001);
      cyc(2);
      chk("motor", motor_run, 0);
      stat("state", 8, 1'b0);
      stat("state", 9, 1'b1);
      wr(OFS_CTRL, 32'h0000_0003);
      cyc(2);
      chk("motor", motor_run, 1);
      $display("test sequence done");
      spd(16'h04B1);
      chk("switchpoint", switchpoint_out, 1);
      stat("switchpoint status", ST_SWITCHPT, 1'b1);
      spd(16'h04B0);
      chk("switchpoint", switchpoint_out, 1);
      spd(16'h04AF);
      chk("switchpoint", switchpoint_out, 0);
      wr(OFS_SP2, 32'h0000_0190);
      wr(OFS_CTRL, 32'h0000_0013);
      spd(16'h03E8);
      chk("switchpoint", switchpoint_out, 0);
      wr(OFS_CTRL, 32'h0000_0012);
      cyc(4);
      chk("switchpoint", switchpoint_out, 1);
      chk("motor", motor_run, 0);
      $display("test switchpoint done");
      wr(OFS_SET_SPD, 32'h0000_01F4);
      wr(OFS_CTRL, 32'h0000_000F);
      cyc(20);
      chk("target", speed_target_hz, 32'h0000_02EE);
      spd(16'h0259);
      chk("switchpoint", switchpoint_out, 1);
      spd(16'h0257);
      chk("switchpoint", switchpoint_out, 0);
      spd(16'h02EF);
      stat("attained", ST_ATTAINED, 1'b1);
      spd(16'h02ED);
      stat("attained", ST_ATTAINED, 1'b0);
      wr(OFS_STANDBY, 32'h0000_0258);
      wr(OFS_CTRL, 32'h0000_0007);
      cyc(2);
      chk("target", speed_target_hz, 32'h0000_0384);
      spd(16'h0385);
      stat("attained", ST_ATTAINED, 1'b1);
      spd(16'h0383);
      stat("attained", ST_ATTAINED, 1'b0);
      $display("test set speed done");
      wr(OFS_BP_ON, 32'h0000_0064);
      wr(OFS_BP_OFF, 32'h0000_0032);
      wr(OFS_CTRL, 32'h0000_0023);
      power_set <= 16'h0064;
      cyc(4);
      chk("backing", backing_pump_out, 1);
      power_set <= 16'h0046;
      cyc(4);
      chk("backing", backing_pump_out, 1);
      power_set <= 16'h0032;
      cyc(4);
      chk("backing", backing_pump_out, 0);
      power_set <= 16'h003C;
      cyc(4);
      chk("backing", backing_pump_out, 0);
      wr(OFS_CTRL, 32'h0000_0040);
      spd(16'h0000);
      wr(OFS_CTRL, 32'h0000_0043);
      cyc(20);
      spd(16'h0006);
      chk("backing", backing_pump_out, 0);
      spd(16'h0007);
      chk("backing", backing_pump_out, 1);
      rd("speed", OFS_SPEED, 32'h0000_0007);
      wr(OFS_CTRL, 32'h0000_0063);
      cyc(2);
      chk("backing", backing_pump_out, 0);
      $display("test backing done");
      wr(OFS_CTRL, 32'h0000_0080);
      cyc(2);
      chk("motor", motor_run, 0);
      cyc(6 * SEC - 2);
      chk("vent", vent_out, 0);
      cyc(2);
      chk("vent", vent_out, 1);
      wr(OFS_CTRL, 32'h0000_0083);
      cyc(2);
      chk("vent", vent_out, 0);
      $display("test vent done");
      wr(OFS_RUNUP, 32'h0000_0001);
      force_en <= 1'b0;
      cyc(4 * SEC);
      stat("run-up error", ST_RUNUP_ERR, 1'b1);
      chk("motor", motor_run, 0);
      $display("test run-up done");
      wrap_up;
   end
endmodule
